// >>> hw/ifd_decoder.sv
`include "ifd_cfg.svh"
`default_nettype none
// Overview of operation
// [RULE1] single words are 24 bits: 8-bit opcode plus operand fields
// [RULE2] only three opcodes take two words; all others decode from one word
// [RULE3] double-word is 48 bits; second word upper 8 bits must be zero
// [RULE4] a second word reached alone decodes as idle instruction
// [RULE5] one cycle normally; taken test or pc change adds one idle cycle
// [RULE6] jumps, indirect/computed, table ops and returns take two or three cycles
// [RULE7] taken skip costs two cycles over one word, three over two
// [RULE8] double-word instructions execute in exactly two cycles
// [RULE9] work-register ops decode base, source with mode, destination with mode
// [RULE10] file ops decode address and destination: same file or accumulator
// [RULE11] bit ops take target plus bit number from literal or register
// [RULE12] literal ops take base and literal; destination only when different
// [RULE13] file address field spans 0000h to 1FFFh
// [RULE14] register fields select sixteen registers; accumulator is register zero
// [RULE15] bit index field is four bits, positions zero to fifteen
// [RULE16] ten-bit literal limited to 255 in byte ops, 1023 in word ops
// [RULE17] 23-bit program address literal must have lsb zero
// [RULE18] signed ten-bit literal is two's complement, -512 to 511
// [RULE19] operands support direct, indirect, post/pre modify, offset forms
// [RULE20] width suffix selects byte, double or word; word by default
// [RULE21] five status bits kept; zero flag is sticky
// [RULE22] opcode is taken from bits 23 to 16
module ifd_decoder (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  output logic fetch_ready,
  input wire logic cond_true,
  input wire logic flag_update,
  input wire logic sticky_z,
  input wire ifd_pkg::ifd_flags_s alu_flags,
  output logic exec_valid,
  output logic exec_first,
  output ifd_pkg::ifd_decoded_s exec_insn,
  output ifd_pkg::ifd_flags_s status_flags
);
  import ifd_pkg::*;

  typedef enum logic [1:0] {
    IFD_ST_RUN = 2'h0, IFD_ST_SECOND = 2'h1,
    IFD_ST_SKIP = 2'h2, IFD_ST_SKIP2 = 2'h3
  } ifd_state_e;

  ifd_state_e state;
  logic [1:0] extra;
  logic [23:0] first_word;
  logic accept;
  logic br_taken;
  logic skip_taken;
  logic drop;
  logic dw_first;
  ifd_decoded_s next_insn;
  logic [1:0] next_extra;

  // true for the three two-word opcodes
  function automatic logic is_dw(input logic [7:0] op);
    is_dw = (op == `IFD_OP_ABS_JUMP) || (op == `IFD_OP_LONG_CALL) ||
            (op == `IFD_OP_DW_MOVE); // RULE2
  endfunction : is_dw

  // addressing mode field, code 7 has no meaning
  function automatic ifd_mode_e to_mode(input logic [2:0] m);
    to_mode = ifd_mode_e'(m); // RULE19
  endfunction : to_mode

  // single-word decode
  function automatic ifd_decoded_s decode_word(input logic [23:0] w);
    ifd_decoded_s d;
    logic [7:0] op;
    d = '0;
    op = w[`IFD_OPC_HI:`IFD_OPC_LO]; // RULE22 RULE1
    d.opcode = op;
    d.iclass = IFD_CL_ILLEGAL;
    d.width = IFD_W_WORD; // RULE20
    d.signed_ten_bit_literal = {{6{w[13]}}, w[13:4]}; // RULE18
    d.jump_offset = w[15:0];
    if (op[7:6] == `IFD_GRP_WORK) begin
      // base, source and destination operands
      d.iclass = IFD_CL_WORK; // RULE9
      d.base_work_reg = op[3:0];
      d.width = ifd_width_e'(w[15:14]); // RULE20
      d.dest_mode = to_mode(w[13:11]);
      d.dest_reg = w[10:7]; // RULE14
      d.source_mode = to_mode(w[6:4]);
      d.source_reg = w[3:0];
      d.illegal = (w[15:14] == 2'h3) || (w[13:11] == 3'h7) ||
                  (w[6:4] == 3'h7); // RULE19
    end else if (op[7:5] == `IFD_GRP_FILE) begin
      // file address and destination select
      d.iclass = IFD_CL_FILE; // RULE10
      d.file_addr = w[12:0]; // RULE13
      d.width = w[13] ? IFD_W_BYTE : IFD_W_WORD;
      d.dest_is_file = op[4];
      d.dest_reg = `IFD_ACC_REG; // RULE14
    end else if (op[7:4] == `IFD_GRP_BIT) begin
      // bit target and bit number
      d.iclass = (op[2:1] == `IFD_SKIP_SEL) ? IFD_CL_SKIP : IFD_CL_BIT; // RULE11
      if (op[3]) begin
        d.file_addr = w[12:0];
        d.bit_index_field = {op[0], w[15:13]}; // RULE15
      end else begin
        d.bit_index_field = w[15:12]; // RULE15
        d.bit_from_reg = w[11];
        d.base_work_reg = w[10:7];
        d.source_mode = to_mode(w[6:4]);
        d.source_reg = w[3:0];
        d.illegal = (w[6:4] == 3'h7);
      end
    end else if (op[7:4] == `IFD_GRP_LIT) begin
      // ten-bit literal into one register
      d.iclass = IFD_CL_LIT;
      d.width = w[14] ? IFD_W_BYTE : IFD_W_WORD;
      d.ten_bit_literal = w[13:4];
      d.base_work_reg = w[3:0];
      d.dest_reg = w[3:0];
      d.illegal = w[14] && (w[13:4] > `IFD_BYTE_LIT_MAX); // RULE16
    end else if (op[7:4] == `IFD_GRP_LIT_BASE) begin
      // base and literal, optional separate destination
      d.iclass = IFD_CL_LIT_BASE; // RULE12
      d.base_work_reg = op[3:0];
      d.width = w[15] ? IFD_W_BYTE : IFD_W_WORD;
      d.dest_reg = w[7] ? w[14:11] : op[3:0]; // RULE12
      d.dest_mode = w[7] ? to_mode(w[10:8]) : IFD_AM_DIRECT;
      d.ten_bit_literal = {5'h00, w[4:0]};
      d.illegal = w[7] && (w[10:8] == 3'h7);
    end else if (op[7:4] == `IFD_GRP_JCOND) begin
      d.iclass = (op == `IFD_OP_JUMP_ALWAYS) ? IFD_CL_JUMP : IFD_CL_JCOND;
    end else begin
      unique case (op)
        `IFD_OP_IDLE: d.iclass = IFD_CL_NOP; // RULE4
        `IFD_OP_COMP_JUMP, `IFD_OP_IND_CALL: begin
          d.iclass = IFD_CL_JIND; // RULE6
          d.source_reg = w[3:0];
        end
        `IFD_OP_RETURN, `IFD_OP_INT_EXIT: d.iclass = IFD_CL_RETURN;
        `IFD_OP_TBL_RD, `IFD_OP_TBL_WR: begin
          d.iclass = IFD_CL_TABLE;
          d.width = w[14] ? IFD_W_BYTE : IFD_W_WORD;
          d.source_mode = to_mode(w[13:11]);
          d.source_reg = w[10:7];
          d.dest_mode = to_mode(w[6:4]);
          d.dest_reg = w[3:0];
        end
        default: d.iclass = IFD_CL_ILLEGAL;
      endcase
      d.illegal = (d.iclass == IFD_CL_ILLEGAL);
    end
    decode_word = d;
  endfunction : decode_word

  // joins the two words of a long instruction
  function automatic ifd_decoded_s decode_dw(input logic [23:0] w1,
                                             input logic [23:0] w2);
    ifd_decoded_s d;
    d = '0;
    d.opcode = w1[`IFD_OPC_HI:`IFD_OPC_LO];
    d.iclass = IFD_CL_DWORD; // RULE8
    d.width = IFD_W_DWORD;
    d.program_addr_literal = {w2[6:0], w1[15:0]};
    d.jump_offset = w2[15:0];
    d.dest_reg = w1[3:0];
    d.illegal = (w2[`IFD_OPC_HI:`IFD_OPC_LO] != `IFD_HI_ZERO) || // RULE3
                ((d.opcode != `IFD_OP_DW_MOVE) && w1[0]); // RULE17
    decode_dw = d;
  endfunction : decode_dw

  // idle cycles that follow each kind
  function automatic logic [1:0] extra_of(input ifd_class_e c);
    unique case (c)
      IFD_CL_JUMP, IFD_CL_JIND: extra_of = `IFD_EXTRA_BRANCH; // RULE6
      IFD_CL_TABLE: extra_of = `IFD_EXTRA_TABLE;
      IFD_CL_RETURN: extra_of = `IFD_EXTRA_RETURN;
      default: extra_of = `IFD_EXTRA_NONE; // RULE5
    endcase
  endfunction : extra_of

  // taken tests resolve in the instruction's own cycle
  assign br_taken = exec_first && (exec_insn.iclass == IFD_CL_JCOND) &&
                    cond_true; // RULE5
  assign skip_taken = exec_first && (exec_insn.iclass == IFD_CL_SKIP) &&
                      cond_true; // RULE7
  assign fetch_ready = (state != IFD_ST_RUN) ||
                       ((extra == 2'h0) && !br_taken);
  assign accept = fetch_valid && fetch_ready;
  assign drop = (state == IFD_ST_SKIP) || (state == IFD_ST_SKIP2) ||
                ((state == IFD_ST_RUN) && skip_taken); // RULE7
  assign dw_first = is_dw(fetch_word[`IFD_OPC_HI:`IFD_OPC_LO]);

  // decoded word for the next cycle
  always_comb begin
    next_insn = '0;
    next_extra = `IFD_EXTRA_NONE;
    if (accept && !drop) begin
      if (state == IFD_ST_SECOND) begin
        next_insn = decode_dw(first_word, fetch_word); // RULE3
      end else if (!dw_first) begin
        next_insn = decode_word(fetch_word);
        next_extra = extra_of(next_insn.iclass);
      end
    end
  end

  // sequencing of words and idle cycles
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= IFD_ST_RUN;
      extra <= 2'h0;
    end else begin
      unique case (state)
        IFD_ST_RUN: begin
          if (accept) begin
            extra <= next_extra;
            if (drop) begin
              state <= dw_first ? IFD_ST_SKIP2 : IFD_ST_RUN; // RULE7
            end else if (dw_first) begin
              state <= IFD_ST_SECOND; // RULE8
            end
          end else if (skip_taken) begin
            state <= IFD_ST_SKIP;
          end else if (extra != 2'h0) begin
            extra <= extra - 2'h1; // RULE6
          end
        end
        IFD_ST_SECOND: if (accept) state <= IFD_ST_RUN;
        IFD_ST_SKIP: if (accept) state <= dw_first ? IFD_ST_SKIP2 : IFD_ST_RUN;
        IFD_ST_SKIP2: if (accept) state <= IFD_ST_RUN;
      endcase
    end
  end

  // holds the first of two words
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      first_word <= 24'h000000;
    end else if (accept && (state == IFD_ST_RUN) && dw_first) begin
      first_word <= fetch_word;
    end
  end

  // execution slot: one entry per instruction cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      exec_valid <= 1'b0;
      exec_first <= 1'b0;
      exec_insn <= '0;
    end else begin
      exec_valid <= accept || (extra != 2'h0) || br_taken; // RULE5
      exec_first <= accept && !drop &&
                    ((state == IFD_ST_SECOND) || !dw_first);
      exec_insn <= next_insn; // idle entries carry all zero
    end
  end

  // status bits, zero kept sticky on request
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      status_flags <= `IFD_FLAGS_RST;
    end else if (flag_update) begin
      status_flags.carry <= alu_flags.carry; // RULE21
      status_flags.nibble_carry <= alu_flags.nibble_carry;
      status_flags.negative <= alu_flags.negative;
      status_flags.signed_range_exceeded <= alu_flags.signed_range_exceeded;
      status_flags.zero <= sticky_z ? (status_flags.zero && alu_flags.zero)
                                    : alu_flags.zero; // RULE21
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // checks on decode and timing
  opcode_take_a: assert property ( // RULE22
    accept && (state == IFD_ST_RUN) && !drop && !dw_first
    |=> exec_first && (exec_insn.opcode == $past(fetch_word[23:16])))
    else $error("opcode not taken from top byte");
  lone_idle_a: assert property ( // RULE4
    accept && (state == IFD_ST_RUN) && !drop && (fetch_word[23:16] == 8'h00)
    |=> exec_insn.iclass == IFD_CL_NOP)
    else $error("zero opcode word not idle");
  dw_two_a: assert property ( // RULE8
    accept && (state == IFD_ST_RUN) && !drop && dw_first
    |=> exec_valid && !exec_first && (state == IFD_ST_SECOND))
    else $error("double word first cycle wrong");
  dw_hi_a: assert property ( // RULE3
    accept && (state == IFD_ST_SECOND) && (fetch_word[23:16] != 8'h00)
    |=> exec_first && exec_insn.illegal)
    else $error("second word high bits not checked");
  branch_two_a: assert property ( // RULE5
    br_taken |-> !fetch_ready ##1 (exec_valid && !exec_first && fetch_ready))
    else $error("taken branch not two cycles");
  return_three_a: assert property ( // RULE6
    exec_first && (exec_insn.iclass == IFD_CL_RETURN) |-> !fetch_ready
    ##1 (exec_valid && !exec_first && !fetch_ready)
    ##1 (exec_valid && !exec_first && fetch_ready))
    else $error("return not three cycles");
  skip_null_a: assert property ( // RULE7
    accept && drop |=> exec_valid && !exec_first)
    else $error("skipped word not idled");
  byte_lit_a: assert property ( // RULE16
    exec_first && (exec_insn.iclass == IFD_CL_LIT) &&
    (exec_insn.width == IFD_W_BYTE) && (exec_insn.ten_bit_literal > 10'h0FF)
    |-> exec_insn.illegal)
    else $error("byte literal above 255 accepted");
  acc_zero_a: assert property ( // RULE14
    exec_first && (exec_insn.iclass == IFD_CL_FILE)
    |-> exec_insn.dest_reg == 4'h0)
    else $error("accumulator not register zero");
  sticky_z_a: assert property ( // RULE21
    flag_update && sticky_z && !alu_flags.zero |=> !status_flags.zero)
    else $error("sticky zero not cleared");
  // flow changes hold the fetch, plain words never do
  jump_two_a: assert property ( // RULE6
    exec_first && ((exec_insn.iclass == IFD_CL_JUMP) ||
    (exec_insn.iclass == IFD_CL_JIND) || (exec_insn.iclass == IFD_CL_TABLE))
    |-> !fetch_ready ##1 (exec_valid && !exec_first && fetch_ready))
    else $error("jump or table not two cycles");
  single_one_a: assert property ( // RULE5
    exec_first && (exec_insn.iclass != IFD_CL_JUMP) &&
    (exec_insn.iclass != IFD_CL_JIND) && (exec_insn.iclass != IFD_CL_TABLE) &&
    (exec_insn.iclass != IFD_CL_RETURN) && (exec_insn.iclass != IFD_CL_JCOND)
    |-> fetch_ready)
    else $error("plain word held the fetch");
  skip_tail_a: assert property ( // RULE7
    accept && (state == IFD_ST_SKIP2)
    |=> exec_valid && !exec_first && (state == IFD_ST_RUN))
    else $error("skipped second word not idled");
  illegal_op_a: assert property ( // RULE2
    exec_first && (exec_insn.iclass == IFD_CL_ILLEGAL) |-> exec_insn.illegal)
    else $error("unknown opcode not flagged");
  // operand fields copied from the word
  lit_base_dst_a: assert property ( // RULE12
    accept && (state == IFD_ST_RUN) && !drop &&
    (fetch_word[23:20] == 4'hC) && !fetch_word[7]
    |=> exec_first && (exec_insn.dest_reg == $past(fetch_word[19:16])))
    else $error("literal result not back in base");
  bit_file_a: assert property ( // RULE15
    accept && (state == IFD_ST_RUN) && !drop &&
    (fetch_word[23:20] == 4'hA) && fetch_word[19]
    |=> exec_insn.bit_index_field == $past({fetch_word[16], fetch_word[15:13]}))
    else $error("file bit number misplaced");
  flag_hold_a: assert property ( // RULE21
    !flag_update |=> $stable(status_flags))
    else $error("status bits moved without update");

  // main scenarios
  cover_dw_c: cover property (accept && (state == IFD_ST_SECOND));
  cover_skip2_c: cover property (accept && (state == IFD_ST_SKIP2));
  cover_branch_c: cover property (br_taken);
  cover_return_c: cover property (exec_first && (exec_insn.iclass == IFD_CL_RETURN));
  cover_lit_base_c: cover property (exec_first && (exec_insn.iclass == IFD_CL_LIT_BASE));
endmodule : ifd_decoder
`default_nettype wire

// >>> hw/ifd_cfg.svh
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH
// opcode position in the fetched word
`define IFD_OPC_HI 23
`define IFD_OPC_LO 16
// exact opcodes
`define IFD_OP_IDLE 8'h00
`define IFD_OP_COMP_JUMP 8'h01
`define IFD_OP_LONG_CALL 8'h02
`define IFD_OP_IND_CALL 8'h03
`define IFD_OP_ABS_JUMP 8'h04
`define IFD_OP_RETURN 8'h06
`define IFD_OP_INT_EXIT 8'h07
`define IFD_OP_DW_MOVE 8'h08
`define IFD_OP_TBL_RD 8'h0A
`define IFD_OP_TBL_WR 8'h0B
`define IFD_OP_JUMP_ALWAYS 8'h37
// opcode groups
`define IFD_GRP_WORK 2'h1
`define IFD_GRP_FILE 3'h4
`define IFD_GRP_JCOND 4'h3
`define IFD_GRP_BIT 4'hA
`define IFD_GRP_LIT 4'hB
`define IFD_GRP_LIT_BASE 4'hC
`define IFD_SKIP_SEL 2'h3
// limits and reset values
`define IFD_BYTE_LIT_MAX 10'h0FF
`define IFD_HI_ZERO 8'h00
`define IFD_ACC_REG 4'h0
`define IFD_FLAGS_RST 5'h00
// extra nop cycles per instruction kind
`define IFD_EXTRA_NONE 2'h0
`define IFD_EXTRA_BRANCH 2'h1
`define IFD_EXTRA_TABLE 2'h1
`define IFD_EXTRA_RETURN 2'h2
`endif

// >>> hw/ifd_pkg.sv
`default_nettype none
package ifd_pkg;
  typedef enum logic [3:0] {
    IFD_CL_NOP = 4'h0, IFD_CL_WORK = 4'h1, IFD_CL_FILE = 4'h2,
    IFD_CL_BIT = 4'h3, IFD_CL_SKIP = 4'h4, IFD_CL_LIT = 4'h5,
    IFD_CL_LIT_BASE = 4'h6, IFD_CL_JCOND = 4'h7, IFD_CL_JUMP = 4'h8,
    IFD_CL_JIND = 4'h9, IFD_CL_TABLE = 4'hA, IFD_CL_RETURN = 4'hB,
    IFD_CL_DWORD = 4'hC, IFD_CL_ILLEGAL = 4'hD
  } ifd_class_e;
  typedef enum logic [1:0] {
    IFD_W_WORD = 2'h0, IFD_W_BYTE = 2'h1, IFD_W_DWORD = 2'h2
  } ifd_width_e;
  typedef enum logic [2:0] {
    IFD_AM_DIRECT = 3'h0, IFD_AM_IND = 3'h1, IFD_AM_POST_INC = 3'h2,
    IFD_AM_POST_DEC = 3'h3, IFD_AM_PRE_INC = 3'h4, IFD_AM_PRE_DEC = 3'h5,
    IFD_AM_OFFSET = 3'h6, IFD_AM_BAD = 3'h7
  } ifd_mode_e;
  typedef struct packed {
    logic [7:0] opcode;
    ifd_class_e iclass;
    ifd_width_e width;
    logic [3:0] base_work_reg;
    logic [3:0] source_reg;
    ifd_mode_e source_mode;
    logic [3:0] dest_reg;
    ifd_mode_e dest_mode;
    logic [12:0] file_addr;
    logic dest_is_file;
    logic [3:0] bit_index_field;
    logic bit_from_reg;
    logic [9:0] ten_bit_literal;
    logic [15:0] signed_ten_bit_literal;
    logic [22:0] program_addr_literal;
    logic [15:0] jump_offset;
    logic illegal;
  } ifd_decoded_s;
  typedef struct packed {
    logic carry;
    logic nibble_carry;
    logic negative;
    logic signed_range_exceeded;
    logic zero;
  } ifd_flags_s;
endpackage : ifd_pkg
`default_nettype wire

// >>> bench/ifd_decoder_bench.sv
`include "ifd_cfg.svh"
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("Error %s expected %0h seen %0h", nm, e, g); n_mismatch++; end end
module ifd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ifd_pkg::*;
  logic ref_clk, reset_n, fetch_valid, cond_true, flag_update, sticky_z;
  logic [23:0] fetch_word;
  ifd_flags_s alu_flags;
  ifd_flags_s status_flags;
  logic fetch_ready, exec_valid, exec_first, idle_bad;
  ifd_decoded_s exec_insn;
  int n_mismatch = 0;
  int samples_checked = 0;
  int waits;
  ifd_decoder ifd_decoder_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready(fetch_ready), .cond_true(cond_true),
    .flag_update(flag_update), .sticky_z(sticky_z), .alu_flags(alu_flags),
    .exec_valid(exec_valid), .exec_first(exec_first), .exec_insn(exec_insn),
    .status_flags(status_flags)
  );
  // free-running instruction clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task step;
    @(posedge ref_clk);
    #5;
  endtask : step
  task wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // offer a word, wait boundedly for ready, noting idle cycles seen
  task take(input logic [23:0] w);
    fetch_valid = 1'b1;
    fetch_word = w;
    idle_bad = 1'b0;
    waits = 0;
    #1;
    while (fetch_ready !== 1'b1 && waits < 8) begin
      @(posedge ref_clk);
      #6;
      waits++;
      idle_bad |= (exec_valid !== 1'b1 || exec_first !== 1'b0 || exec_insn !== '0);
    end
    if (waits == 8) begin
      $display("Error fetch_ready wait ran out");
      n_mismatch++;
      wrap_up();
    end
    step();
  endtask : take
  task idle;
    fetch_valid = 1'b0;
    step();
  endtask : idle
  // all address modes and widths, back to back
  task t_work;
    for (int m = 0; m < 7; m++) begin
      take({8'h4B, 2'(m % 3), 3'(m), 4'h9, 3'(6 - m), 4'hF});
      `CHK("wait", 0, waits)
      `CHK("class", IFD_CL_WORK, exec_insn.iclass)
      `CHK("opcode", 8'h4B, exec_insn.opcode)
      `CHK("base", 4'hB, exec_insn.base_work_reg)
      `CHK("regs", 8'h9F, {exec_insn.dest_reg, exec_insn.source_reg})
      `CHK("dmode", 3'(m), exec_insn.dest_mode)
      `CHK("smode", 3'(6 - m), exec_insn.source_mode)
      `CHK("width", 2'(m % 3), exec_insn.width)
      `CHK("first", 2'b11, {exec_valid, exec_first})
    end
    idle();
  endtask : t_work
  // both destinations, both ends of the address range
  task t_file;
    take({8'h90, 3'b000, 13'h1FFF});
    `CHK("faddr", 13'h1FFF, exec_insn.file_addr)
    `CHK("fdst", 1'b1, exec_insn.dest_is_file)
    `CHK("fwid", IFD_W_WORD, exec_insn.width)
    take({8'h80, 3'b001, 13'h0000});
    `CHK("faddr", 13'h0000, exec_insn.file_addr)
    `CHK("fdst", 1'b0, exec_insn.dest_is_file)
    `CHK("fcls", IFD_CL_FILE, exec_insn.iclass)
    `CHK("facc", 4'h0, exec_insn.dest_reg)
    idle();
  endtask : t_file
  // literal limits per width and sign extension
  task t_lit;
    logic [9:0] lv [4];
    lv = '{10'h3FF, 10'h200, 10'h0FF, 10'h100};
    for (int i = 0; i < 4; i++) begin
      take({8'hB0, 1'b0, 1'(i / 2), lv[i], 4'h5});
      `CHK("lcls", IFD_CL_LIT, exec_insn.iclass)
      `CHK("lit", lv[i], exec_insn.ten_bit_literal)
      `CHK("slit", {{6{lv[i][9]}}, lv[i]}, exec_insn.signed_ten_bit_literal)
      `CHK("lill", 1'(i == 3), exec_insn.illegal)
    end
    // base plus short literal, result back in base
    take({8'hC5, 1'b1, 4'h0, 3'h0, 1'b0, 2'h0, 5'h1F});
    `CHK("bdst", 4'h5, exec_insn.dest_reg)
    `CHK("blit", 10'h01F, exec_insn.ten_bit_literal)
    `CHK("bwid", IFD_W_BYTE, exec_insn.width)
    // separate destination with its own mode
    take({8'hC5, 1'b0, 4'h9, 3'h2, 1'b1, 2'h0, 5'h03});
    `CHK("bcls", IFD_CL_LIT_BASE, exec_insn.iclass)
    `CHK("bdst", 4'h9, exec_insn.dest_reg)
    `CHK("bdmd", 3'h2, exec_insn.dest_mode)
    // unknown opcode is flagged and takes one cycle
    take(24'h0F0000);
    `CHK("iwait", 0, waits)
    `CHK("icls", IFD_CL_ILLEGAL, exec_insn.iclass)
    `CHK("ill", 1'b1, exec_insn.illegal)
    idle();
  endtask : t_lit
  // bit number from literal and from register
  task t_bit;
    take({8'hA9, 3'b111, 13'h0000});
    `CHK("bit", 4'hF, exec_insn.bit_index_field)
    `CHK("bcls", IFD_CL_BIT, exec_insn.iclass)
    take({8'hA0, 4'hA, 1'b1, 4'h3, 3'h0, 4'h2});
    `CHK("bit", 4'hA, exec_insn.bit_index_field)
    `CHK("breg", 1'b1, exec_insn.bit_from_reg)
    idle();
  endtask : t_bit
  // refused cycles after flow changes, idles in between
  task t_cycles;
    logic [7:0] ops [9];
    int ex [9];
    ops = '{8'h37, 8'h01, 8'h03, 8'h0A, 8'h0B, 8'h06, 8'h07, 8'h30, 8'h30};
    ex = '{1, 1, 1, 1, 1, 2, 2, 1, 0};
    for (int i = 0; i < 9; i++) begin
      take({ops[i], 16'h0000});
      cond_true = (i == 7);
      take(24'h400000);
      `CHK("extra", ex[i], waits)
      `CHK("idle", 1'b0, idle_bad)
      cond_true = 1'b0;
    end
    idle();
  endtask : t_cycles
  // double words, odd address and bad second word, lone second word
  task t_double;
    logic [7:0] ops [3];
    ops = '{8'h02, 8'h04, 8'h08};
    for (int i = 0; i < 3; i++) begin
      take({ops[i], 16'h1234});
      `CHK("dw1", 2'b10, {exec_valid, exec_first})
      take(24'h000055);
      `CHK("dw2", 2'b11, {exec_valid, exec_first})
      `CHK("dcls", IFD_CL_DWORD, exec_insn.iclass)
      `CHK("dill", 1'b0, exec_insn.illegal)
    end
    `CHK("paddr", 23'h551234, exec_insn.program_addr_literal)
    take({8'h04, 16'h1235});
    take(24'h000055);
    `CHK("odd", 1'b1, exec_insn.illegal)
    take({8'h04, 16'h1234});
    take(24'h010055);
    `CHK("hi", 1'b1, exec_insn.illegal)
    take(24'h000055);
    `CHK("lone", IFD_CL_NOP, exec_insn.iclass)
    idle();
  endtask : t_double
  // taken skip over one word, then over a double word
  task t_skip;
    take(24'hA60000);
    cond_true = 1'b1;
    take(24'h400000);
    `CHK("skip1", 2'b10, {exec_valid, exec_first})
    cond_true = 1'b0;
    take(24'hA60000);
    cond_true = 1'b1;
    take(24'h020000);
    `CHK("skip2", 1'b0, exec_first)
    cond_true = 1'b0;
    take(24'h000000);
    `CHK("skip3", 1'b0, exec_first)
    take(24'h400000);
    `CHK("after", 1'b1, exec_first)
    idle();
  endtask : t_skip
  // overwrite and sticky zero updates
  task t_flags;
    logic [4:0] a [5];
    logic [4:0] e [5];
    a = '{5'h1F, 5'h1E, 5'h01, 5'h01, 5'h10};
    e = '{5'h1F, 5'h1E, 5'h00, 5'h01, 5'h10};
    for (int i = 0; i < 5; i++) begin
      alu_flags = a[i];
      sticky_z = (i == 2 || i == 4);
      flag_update = 1'b1;
      step();
      flag_update = 1'b0;
      step();
      `CHK("flags", e[i], status_flags)
    end
  endtask : t_flags
  initial begin
    reset_n = 1'b0;
    fetch_valid = 1'b0;
    fetch_word = '0;
    cond_true = 1'b0;
    flag_update = 1'b0;
    sticky_z = 1'b0;
    alu_flags = '0;
    repeat (3) step();
    `CHK("rst_ready", 1'b1, fetch_ready)
    `CHK("rst_flags", 5'h00, status_flags)
    reset_n = 1'b1;
    step();
    `CHK("rst_exec", 2'b00, {exec_valid, exec_first})
    t_work();
    t_file();
    t_lit();
    t_bit();
    t_cycles();
    t_double();
    t_skip();
    t_flags();
    wrap_up();
  end
endmodule : ifd_decoder_bench
`default_nettype wire
